/* File: lesr_host.sv */
// Host model: one strobed register read, answer taken a cycle later.
// Shares the status block clock; drives on the falling edge.
`timescale 1ns/100ps
module lesr_host (
  // Clock and read port
  input  wire logic       clk_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_stb_o,
  output logic      [7:0] rd_addr_o
);
  // ------------
  // Read cycle
  // ------------
  initial {rd_stb_o, rd_addr_o} = 9'h000;
  // Idle address is inverted so a stale value is never mistaken for a request
  task automatic read(input logic [7:0] a, output logic [8:0] r);
    @(negedge clk_i);
    {rd_stb_o, rd_addr_o} = {1'b1, a};
    @(negedge clk_i);
    r = {rd_valid_i, rd_data_i};
    {rd_stb_o, rd_addr_o} = {1'b0, ~a};
  endtask
endmodule

/* File: lesr_params.svh */
// Constants for the limit event status registers: offsets, bit positions,
// reset values and widths. Included by the package and the design module.
`ifndef LESR_PARAMS_SVH
`define LESR_PARAMS_SVH

// Register offsets on the management bus
`define LESR_ADDR_STATUS_A 8'h41
`define LESR_ADDR_STATUS_B 8'h42

// Reset values and read answers
`define LESR_RESET_BYTE    8'h00
`define LESR_UNMAPPED_BYTE 8'h00

// Status A bit positions
`define LESR_A_V2P5        0
`define LESR_A_VCORE       1
`define LESR_A_VCC         2
`define LESR_A_V5          3
`define LESR_A_REMOTE1     4
`define LESR_A_ONCHIP      5
`define LESR_A_REMOTE2     6
`define LESR_A_SUMMARY     7

// Status B bit positions
`define LESR_B_V12         0
`define LESR_B_SUMMARY     1
`define LESR_B_FIRST_FAN_SPEED_FLAG        2
`define LESR_B_SECOND_FAN_SPEED_FLAG        3
`define LESR_B_THIRD_FAN_SPEED_FLAG        4
`define LESR_B_FOURTH_FAN_SPEED_FLAG        5
`define LESR_B_DIODE1      6
`define LESR_B_DIODE2      7

// Index of each voltage and temperature channel in the packed inputs
`define LESR_VCH_V2P5      0
`define LESR_VCH_VCORE     1
`define LESR_VCH_VCC       2
`define LESR_VCH_V5        3
`define LESR_VCH_V12       4
`define LESR_TCH_REMOTE1   0
`define LESR_TCH_ONCHIP    1
`define LESR_TCH_REMOTE2   2

// Channel counts and widths
`define LESR_NUM_VOLT      5
`define LESR_NUM_TEMP      3
`define LESR_NUM_FAN       4
`define LESR_FOURTH_FAN_SPEED_FLAG_PWM      2
`define LESR_BYTE_W        8

`endif

/* File: lesr_pkg.sv */
// Types shared by the limit event status register block.
// Assumes lesr_params.svh sits in the include path.
`include "lesr_params.svh"

package lesr_pkg;

  typedef logic [`LESR_BYTE_W-1:0] lesr_byte_t;
  typedef logic [`LESR_BYTE_W-1:0] lesr_flags_t;

endpackage

/* File: lesr_status_regs.sv */
// Two sticky limit event status registers with clear-on-read.
// Readings, limits, fan faults and pin modes come from logic on MCLK_I;
// the management bus slave presents one read strobe per register read.
//
// Overview of operation
// RULE1 - Status A read-only, offset 0x41, resets zero
// RULE2 - Status B read-only, offset 0x42, resets zero
// RULE3 - Flags sticky; read clears only absent causes
// RULE4 - A bit0: 2.5 V above high or at-below low
// RULE5 - A bit0 follows throttle timer when pin throttles
// RULE6 - A bits1-3: core, supply, 5 V limits
// RULE7 - A bit4: first remote temperature limits
// RULE8 - A bit5: on-chip temperature limits
// RULE9 - A bit6: second remote temperature limits
// RULE10 - A bit7 reads OR of status B
// RULE11 - B bit0: 12 V input limits
// RULE12 - B bit1 reads OR of status C
// RULE13 - B bits2-4: fans 1-3 slow or stalled
// RULE14 - Fan flags suppressed while pulse output off
// RULE15 - B bit5: fan 4 or throttle timer
// RULE16 - B bit6: first diode open or short
// RULE17 - B bit7: second diode open or short
// RULE18 - High is strictly above; low is at-or-below
// RULE19 - Clear after capture; same-cycle event stays latched
`timescale 1ns/100ps
`include "lesr_params.svh"

module lesr_status_regs #(
  parameter int NUM_VOLT = `LESR_NUM_VOLT,
  parameter int NUM_TEMP = `LESR_NUM_TEMP,
  parameter int NUM_FAN  = `LESR_NUM_FAN
) (
  // Clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  RST_I,
  // Register read port from the management bus slave
  input  wire logic                  RD_STB_I,
  input  wire logic [7:0]            RD_ADDR_I,
  output logic      [7:0]            RD_DATA_O,
  output logic                       RD_VALID_O,
  // Voltage readings and limits, one byte per channel
  input  wire logic [NUM_VOLT*8-1:0] VOLT_READING_I,
  input  wire logic [NUM_VOLT*8-1:0] VOLT_LOW_LIMIT_I,
  input  wire logic [NUM_VOLT*8-1:0] VOLT_HIGH_LIMIT_I,
  // Temperature readings and limits, two's complement bytes
  input  wire logic [NUM_TEMP*8-1:0] TEMP_READING_I,
  input  wire logic [NUM_TEMP*8-1:0] TEMP_LOW_LIMIT_I,
  input  wire logic [NUM_TEMP*8-1:0] TEMP_HIGH_LIMIT_I,
  // Fan speed faults from the tachometer logic and pulse outputs
  input  wire logic [NUM_FAN-1:0]    FAN_SLOW_I,
  input  wire logic [2:0]            PWM_ACTIVE_I,
  // Shared pins and throttle timer
  input  wire logic                  PIN22_IS_THROTTLE_I,
  input  wire logic                  PIN14_IS_THROTTLE_I,
  input  wire logic                  THROTTLE_TIMER_OVER_I,
  // Thermal diode faults
  input  wire logic                  DIODE1_FAULT_I,
  input  wire logic                  DIODE2_FAULT_I,
  // Third status register contents, for the summary bit
  input  wire logic [7:0]            STATUS_C_I,
  // Current flags
  output logic      [7:0]            STATUS_A_O,
  output logic      [7:0]            STATUS_B_O
);

  // ----------------------------------------------------------------
  // Limit comparators
  // ----------------------------------------------------------------
  logic [NUM_VOLT-1:0] volt_out;
  logic [NUM_TEMP-1:0] temp_out;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_VOLT; gi++) begin : g_volt
      logic [7:0] rd;
      logic [7:0] lo;
      logic [7:0] hi;
      assign rd = VOLT_READING_I[gi*8 +: 8];
      assign lo = VOLT_LOW_LIMIT_I[gi*8 +: 8];
      assign hi = VOLT_HIGH_LIMIT_I[gi*8 +: 8];
      assign volt_out[gi] = (rd > hi) || (rd <= lo); // RULE18
    end
    // Temperatures are signed, so the compare must be too
    for (gi = 0; gi < NUM_TEMP; gi++) begin : g_temp
      logic signed [7:0] rd;
      logic signed [7:0] lo;
      logic signed [7:0] hi;
      assign rd = TEMP_READING_I[gi*8 +: 8];
      assign lo = TEMP_LOW_LIMIT_I[gi*8 +: 8];
      assign hi = TEMP_HIGH_LIMIT_I[gi*8 +: 8];
      assign temp_out[gi] = (rd > hi) || (rd <= lo); // RULE18
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event causes
  // ----------------------------------------------------------------
  lesr_pkg::lesr_flags_t cause_a;
  lesr_pkg::lesr_flags_t cause_b;
  logic                  fourth_fan_speed_flag_cause;
  logic [NUM_FAN-2:0]    fan_cause;

  // Fans 1 to 3 each gate on their own pulse output
  generate
    for (gi = 0; gi < NUM_FAN - 1; gi++) begin : g_fan
      assign fan_cause[gi] = FAN_SLOW_I[gi] & PWM_ACTIVE_I[gi]; // RULE13 RULE14
    end
  endgenerate

  // Fan 4 shares the third pulse output
  assign fourth_fan_speed_flag_cause = FAN_SLOW_I[NUM_FAN-1] & PWM_ACTIVE_I[`LESR_FOURTH_FAN_SPEED_FLAG_PWM]; // RULE14

  always_comb begin
    cause_a = `LESR_RESET_BYTE;
    cause_b = `LESR_RESET_BYTE;
    cause_a[`LESR_A_V2P5] = PIN22_IS_THROTTLE_I ? THROTTLE_TIMER_OVER_I // RULE5
                                                : volt_out[`LESR_VCH_V2P5]; // RULE4
    cause_a[`LESR_A_VCORE]   = volt_out[`LESR_VCH_VCORE]; // RULE6
    cause_a[`LESR_A_VCC]     = volt_out[`LESR_VCH_VCC]; // RULE6
    cause_a[`LESR_A_V5]      = volt_out[`LESR_VCH_V5]; // RULE6
    cause_a[`LESR_A_REMOTE1] = temp_out[`LESR_TCH_REMOTE1]; // RULE7
    cause_a[`LESR_A_ONCHIP]  = temp_out[`LESR_TCH_ONCHIP]; // RULE8
    cause_a[`LESR_A_REMOTE2] = temp_out[`LESR_TCH_REMOTE2]; // RULE9
    cause_b[`LESR_B_V12]     = volt_out[`LESR_VCH_V12]; // RULE11
    cause_b[`LESR_B_THIRD_FAN_SPEED_FLAG:`LESR_B_FIRST_FAN_SPEED_FLAG] = fan_cause; // RULE13 RULE14
    cause_b[`LESR_B_FOURTH_FAN_SPEED_FLAG]    = PIN14_IS_THROTTLE_I ? THROTTLE_TIMER_OVER_I
                                                   : fourth_fan_speed_flag_cause; // RULE15
    cause_b[`LESR_B_DIODE1]  = DIODE1_FAULT_I; // RULE16
    cause_b[`LESR_B_DIODE2]  = DIODE2_FAULT_I; // RULE17
  end

  // ----------------------------------------------------------------
  // Sticky flags and read port
  // ----------------------------------------------------------------
  lesr_pkg::lesr_flags_t flags_a;
  lesr_pkg::lesr_flags_t flags_b;
  lesr_pkg::lesr_flags_t next_flags_a;
  lesr_pkg::lesr_flags_t next_flags_b;
  lesr_pkg::lesr_byte_t  view_a;
  lesr_pkg::lesr_byte_t  view_b;
  lesr_pkg::lesr_byte_t  rd_data;
  lesr_pkg::lesr_byte_t  next_rd_data;
  logic                  rd_valid;
  logic                  next_rd_valid;
  logic                  clr_a;
  logic                  clr_b;

  // Summary bits are live ORs, never stored, so they cannot go stale
  always_comb begin
    view_a = flags_a;
    view_b = flags_b;
    view_b[`LESR_B_SUMMARY] = |STATUS_C_I; // RULE12
    view_a[`LESR_A_SUMMARY] = |view_b; // RULE10
  end

  assign clr_a = RD_STB_I && (RD_ADDR_I == `LESR_ADDR_STATUS_A); // RULE1
  assign clr_b = RD_STB_I && (RD_ADDR_I == `LESR_ADDR_STATUS_B); // RULE2

  always_comb begin
    // The read returns the flags as they stand; the clear lands on the
    // same edge, and a cause present now is ORed back so it wins
    next_flags_a = flags_a;
    next_flags_b = flags_b;
    if (clr_a) begin
      next_flags_a = flags_a & cause_a; // RULE3 RULE19
    end
    if (clr_b) begin
      next_flags_b = flags_b & cause_b; // RULE3 RULE19
    end
    next_flags_a = next_flags_a | cause_a; // RULE3 RULE19
    next_flags_b = next_flags_b | cause_b; // RULE3 RULE19
    next_flags_a[`LESR_A_SUMMARY] = 1'b0;
    next_flags_b[`LESR_B_SUMMARY] = 1'b0;
  end

  always_comb begin
    next_rd_valid = RD_STB_I;
    next_rd_data  = rd_data;
    if (RD_STB_I) begin
      case (RD_ADDR_I)
        `LESR_ADDR_STATUS_A: begin
          next_rd_data = view_a; // RULE1 RULE19
        end
        `LESR_ADDR_STATUS_B: begin
          next_rd_data = view_b; // RULE2 RULE19
        end
        default: begin
          next_rd_data = `LESR_UNMAPPED_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_a  <= `LESR_RESET_BYTE; // RULE1
      flags_b  <= `LESR_RESET_BYTE; // RULE2
      rd_data  <= `LESR_RESET_BYTE;
      rd_valid <= 1'b0;
    end else begin
      flags_a  <= next_flags_a;
      flags_b  <= next_flags_b;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  assign RD_DATA_O  = rd_data;
  assign RD_VALID_O = rd_valid;
  assign STATUS_A_O = view_a;
  assign STATUS_B_O = view_b;

endmodule

/* File: lesr_status_regs_asserts.sv */
// Checker for the status register read port, summaries and status B sticky flags.
// Bound to lesr_status_regs; sees its ports only.
`timescale 1ns/100ps
module lesr_status_regs_asserts (
  // Clock, reset and read port
  input wire logic       MCLK_I,
  input wire logic       RST_I,
  input wire logic       RD_STB_I,
  input wire logic [7:0] RD_ADDR_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic       RD_VALID_O,
  // Status views
  input wire logic [7:0] STATUS_C_I,
  input wire logic [7:0] STATUS_A_O,
  input wire logic [7:0] STATUS_B_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // ------------
  // Read answers
  // ------------
  sequence s_rd_a; RD_STB_I && RD_ADDR_I == 8'h41; endsequence
  sequence s_rd_b; RD_STB_I && RD_ADDR_I == 8'h42; endsequence
  a_valid_pulse: assert property (RD_STB_I |=> RD_VALID_O) else $error("no valid");
  a_valid_idle: assert property (!RD_STB_I |=> !RD_VALID_O) else $error("stray valid");
  a_read_a_data: assert property (s_rd_a |=> RD_DATA_O == $past(STATUS_A_O))
    else $error("bad A data");
  a_read_b_data: assert property (s_rd_b |=> RD_DATA_O == $past(STATUS_B_O))
    else $error("bad B data");
  a_unmapped_zero: assert property (RD_STB_I && !(RD_ADDR_I inside {8'h41, 8'h42})
    |=> RD_DATA_O == 8'h00) else $error("unmapped data");
  a_summary_a: assert property (STATUS_A_O[7] == |STATUS_B_O) else $error("A summary");
  a_summary_b: assert property (STATUS_B_O[1] == |STATUS_C_I) else $error("B summary");
  // Summary bit 1 is live, so it is masked out of the sticky check
  a_b_sticky: assert property (!RD_STB_I |=>
    (($past(STATUS_B_O) & ~STATUS_B_O) & 8'hfd) == 8'h00) else $error("flag lost");
endmodule
bind lesr_status_regs lesr_status_regs_asserts u_lesr_status_regs_asserts (.*);

/* File: testbench.sv */
// Self-checking bench: status reads through the host model.
// Assumes design, host model and checker compiled first.
`timescale 1ns/100ps
module testbench;
  logic        MCLK_I = 1'b0;
  logic        RST_I, RD_STB_I, RD_VALID_O, DIODE1_FAULT_I, DIODE2_FAULT_I;
  logic        PIN22_IS_THROTTLE_I, PIN14_IS_THROTTLE_I, THROTTLE_TIMER_OVER_I;
  logic [7:0]  RD_ADDR_I, RD_DATA_O, STATUS_C_I, STATUS_A_O, STATUS_B_O;
  logic [39:0] VOLT_READING_I, VOLT_LOW_LIMIT_I, VOLT_HIGH_LIMIT_I;
  logic [23:0] TEMP_READING_I, TEMP_LOW_LIMIT_I, TEMP_HIGH_LIMIT_I;
  logic [3:0]  FAN_SLOW_I;
  logic [2:0]  PWM_ACTIVE_I;
  int          miscompares = 0;
  int          n_checks = 0;
  lesr_status_regs u_lesr_status_regs (.*);
  lesr_host u_lesr_host (.clk_i(MCLK_I), .rd_valid_i(RD_VALID_O), .rd_data_i(RD_DATA_O),
    .rd_stb_o(RD_STB_I), .rd_addr_o(RD_ADDR_I));
  // ------------
  // Run control
  // ------------
  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] r;
    u_lesr_host.read(a, r);
    n_checks++;
    if (r !== {1'b1, e}) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, r, {1'b1, e});
    end
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  initial forever #20 MCLK_I = ~MCLK_I;
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    RST_I = 1'b1;
    {VOLT_READING_I, VOLT_LOW_LIMIT_I, VOLT_HIGH_LIMIT_I} = {{5{8'h80}}, {5{8'h10}}, {5{8'hf0}}};
    {TEMP_READING_I, TEMP_LOW_LIMIT_I, TEMP_HIGH_LIMIT_I} = {{3{8'h19}}, {3{8'h81}}, {3{8'h40}}};
    {DIODE1_FAULT_I, DIODE2_FAULT_I, STATUS_C_I, FAN_SLOW_I, PWM_ACTIVE_I} = '0;
    {PIN22_IS_THROTTLE_I, PIN14_IS_THROTTLE_I, THROTTLE_TIMER_OVER_I} = 3'h0;
    repeat (12) @(negedge MCLK_I);
    RST_I = 1'b0;
    rd(8'h41, 8'h00);
    rd(8'h43, 8'h00);
    // Reading at the high limit, or a negative temperature, must stay quiet
    for (int i = 0; i < 5; i++) begin
      VOLT_READING_I[i*8 +: 8] = 8'hf0;
      TEMP_READING_I[(i%3)*8 +: 8] = 8'hc0;
      @(negedge MCLK_I);
      VOLT_READING_I[i*8 +: 8] = 8'h10;
      TEMP_READING_I[(i%3)*8 +: 8] = 8'h41;
      @(negedge MCLK_I);
      VOLT_READING_I[i*8 +: 8] = 8'h80;
      TEMP_READING_I[(i%3)*8 +: 8] = 8'h19;
      rd(8'h41, (i < 4 ? 8'h01 << i : 8'h80) | 8'h10 << (i%3));
      rd(8'h42, i < 4 ? 8'h00 : 8'h01);
      rd(8'h41, 8'h00);
    end
    {FAN_SLOW_I, PWM_ACTIVE_I} = {4'hf, 3'h4};
    @(negedge MCLK_I);
    rd(8'h42, 8'h30);
    FAN_SLOW_I = 4'h0;
    rd(8'h42, 8'h30);
    {PIN22_IS_THROTTLE_I, PIN14_IS_THROTTLE_I, THROTTLE_TIMER_OVER_I} = 3'h7;
    {DIODE1_FAULT_I, DIODE2_FAULT_I, STATUS_C_I} = {2'h3, 8'h04};
    @(negedge MCLK_I);
    THROTTLE_TIMER_OVER_I = 1'b0;
    rd(8'h42, 8'he2);
    rd(8'h42, 8'hc2);
    rd(8'h41, 8'h81);
    chk(STATUS_A_O, 8'h80);
    chk(STATUS_B_O, 8'hc2);
    finish_test();
  end
endmodule
